/* File: logic/wwrs_pkg.sv */
// package for the wake-up watchdog reset supervisor
`default_nettype none
package wwrs_pkg;
   // ****************************************************************
   // timing ratios (ticks of the timebase)
   // ****************************************************************
   // wake period : reset delay : reset-high-to-wake = 8 : 1 : 4
   localparam int unsigned WAKE_RATIO       = 8;
   localparam int unsigned RST_RATIO        = 1;
   localparam int unsigned R2W_RATIO        = 4;
   // default units of the timebase per ratio step
   localparam int unsigned UNIT_TICKS_DEF   = 16;
   // default tick divider, in sys clocks
   localparam int unsigned TICK_DIV_DEF     = 25;
   localparam int unsigned CNT_W            = 24;
   // response time to a kick, typical, and its cycle count
   localparam int unsigned KICK_RESP_NS     = 2000;
   localparam int unsigned CLK_PERIOD_NS    = 40;
   localparam int unsigned KICK_RESP_CYC    = KICK_RESP_NS / CLK_PERIOD_NS;
   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_RESET,
      ST_DELAY,
      ST_WAKE
   } wwrs_state_t;

   typedef struct packed {
      logic rst_n;
      logic wake;
   } wwrs_out_t;
endpackage : wwrs_pkg
`default_nettype wire

/* File: logic/wwrs_tick.sv */
// timebase tick divider
`timescale 1ns/100ps
`default_nettype none
module wwrs_tick #(
   parameter int unsigned DIV = wwrs_pkg::TICK_DIV_DEF
) (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   // tick pulse
   output logic      tick_out
);
   logic [23:0] cnt_q;
   logic [23:0] cnt_d;
   logic        tick_d;

   always_comb begin
      if (cnt_q == 24'(DIV - 1)) begin
         cnt_d  = 24'h000000;
         tick_d = 1'b1;
      end else begin
         cnt_d  = cnt_q + 24'h000001;
         tick_d = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q    <= 24'h000000;
         tick_out <= 1'b0;
      end else begin
         cnt_q    <= cnt_d;
         tick_out <= tick_d;
      end
   end
endmodule : wwrs_tick
`default_nettype wire

/* File: logic/wwrs_top.sv */
// supervisor: wake-up square wave, watchdog, reset
`timescale 1ns/100ps
`default_nettype none
// Contract
// R1: wake output is a continuous 50 percent square wave set by the timebase.
// R2: only falling edges of the kick input count.
// R3: the processor kicks after each rising wake edge, then picks a mode.
// R4: first kick in a cycle drives wake low soon, until the next cycle.
// R5: later kicks in the same cycle are ignored.
// R6: at power-up reset stays low until output good.
// R7: undervoltage asserts reset for as long as it lasts.
// R8: after recovery reset stays low one reset delay, then goes high.
// R9: a cycle with no kick ends in a reset pulse of one reset delay.
// R10: wake is held low while reset is asserted.
// R11: after reset release, wait the reset-to-wake delay, then start cycles.
// R12: all intervals share one timebase in fixed ratios.
// R13: one setting fixes all three intervals together.
// R14: a system without watchdog ties wake back to the kick input.
// R15: the kick input is synchronised before edge detection.
// R16: intervals count timebase ticks in ratio 8:1:4.
module wwrs_top #(
   parameter int unsigned TICK_DIV   = wwrs_pkg::TICK_DIV_DEF,
   parameter int unsigned UNIT_TICKS = wwrs_pkg::UNIT_TICKS_DEF
) (
   // clock and reset
   input  wire logic sys_clk_in,
   input  wire logic resetn_in,
   // regulator status
   input  wire logic out_good_in,
   input  wire logic undervolt_in,
   // processor side
   input  wire logic watchdog_kick_in,
   output logic      wake_out,
   output logic      reset_n_out
);
   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int unsigned CW = wwrs_pkg::CNT_W;
   // R13 one setting
   // R12 shared ratios
   // R16 ratio 8:1:4
   localparam logic [CW-1:0] WAKE_T =
      CW'(wwrs_pkg::WAKE_RATIO * UNIT_TICKS);
   localparam logic [CW-1:0] HALF_T =
      CW'(wwrs_pkg::WAKE_RATIO * UNIT_TICKS / 2);
   localparam logic [CW-1:0] RST_T  =
      CW'(wwrs_pkg::RST_RATIO * UNIT_TICKS);
   localparam logic [CW-1:0] R2W_T  =
      CW'(wwrs_pkg::R2W_RATIO * UNIT_TICKS);

   // ****************************************************************
   // reset release and input sync
   // ****************************************************************
   logic [1:0] rsync_q;
   logic       rst_n;

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rsync_q <= 2'h0;
      end else begin
         rsync_q <= {rsync_q[0], 1'b1};
      end
   end
   assign rst_n = rsync_q[1];

   // pins are async: three stages, a change counts when 2 and 3 agree
   logic [2:0] kick_q;
   logic [2:0] good_q;
   logic [2:0] uv_q;
   logic       kick_lvl_q;
   logic       kick_lvl_d;
   logic       good_lvl_q;
   logic       good_lvl_d;
   logic       uv_lvl_q;
   logic       uv_lvl_d;
   logic       kick_fall;

   always_comb begin
      kick_lvl_d = kick_lvl_q;
      good_lvl_d = good_lvl_q;
      uv_lvl_d   = uv_lvl_q;
      if (kick_q[1] == kick_q[2]) begin
         kick_lvl_d = kick_q[2];
      end
      if (good_q[1] == good_q[2]) begin
         good_lvl_d = good_q[2];
      end
      if (uv_q[1] == uv_q[2]) begin
         uv_lvl_d = uv_q[2];
      end
   end

   // R15 synchronise kick
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         kick_q     <= 3'h0;
         good_q     <= 3'h0;
         uv_q       <= 3'h0;
         kick_lvl_q <= 1'b0;
         good_lvl_q <= 1'b0;
         uv_lvl_q   <= 1'b0;
      end else begin
         kick_q     <= {kick_q[1:0], watchdog_kick_in};
         good_q     <= {good_q[1:0], out_good_in};
         uv_q       <= {uv_q[1:0], undervolt_in};
         kick_lvl_q <= kick_lvl_d;
         good_lvl_q <= good_lvl_d;
         uv_lvl_q   <= uv_lvl_d;
      end
   end

   // R2 falling edges only
   assign kick_fall = kick_lvl_q & ~kick_lvl_d;

   // ****************************************************************
   // timebase
   // ****************************************************************
   logic tick;

   wwrs_tick #(
      .DIV (TICK_DIV)
   ) u_tick (
      .clk_in   (sys_clk_in),
      .rst_n_in (rst_n),
      .tick_out (tick)
   );

   // ****************************************************************
   // supervisor state machine
   // ****************************************************************
   wwrs_pkg::wwrs_state_t state_q;
   wwrs_pkg::wwrs_state_t state_d;
   logic [CW-1:0]         cnt_q;
   logic [CW-1:0]         cnt_d;
   logic                  kicked_q;
   logic                  kicked_d;
   logic                  powered_q;
   logic                  powered_d;
   wwrs_pkg::wwrs_out_t   out_q;
   wwrs_pkg::wwrs_out_t   out_d;
   logic                  supply_bad;

   // before first good, reset holds regardless of the flag
   assign supply_bad = uv_lvl_q | (~powered_q & ~good_lvl_q);

   always_comb begin
      state_d   = state_q;
      cnt_d     = cnt_q;
      kicked_d  = kicked_q;
      powered_d = powered_q | good_lvl_q;
      out_d     = out_q;
      unique case (state_q)
         wwrs_pkg::ST_RESET: begin
            // R10 wake low in reset
            out_d.wake  = 1'b0;
            out_d.rst_n = 1'b0;
            if (supply_bad) begin
               // R6 hold until good
               // R7 undervoltage holds
               cnt_d = '0;
            end else if (tick) begin
               // R8 one reset delay
               if (cnt_q == RST_T - 1'b1) begin
                  state_d     = wwrs_pkg::ST_DELAY;
                  cnt_d       = '0;
                  out_d.rst_n = 1'b1;
               end else begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
         end
         wwrs_pkg::ST_DELAY: begin
            out_d.wake = 1'b0;
            // R11 delay before first wake
            if (tick) begin
               if (cnt_q == R2W_T - 1'b1) begin
                  state_d    = wwrs_pkg::ST_WAKE;
                  cnt_d      = '0;
                  kicked_d   = 1'b0;
                  out_d.wake = 1'b1;
               end else begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
         end
         wwrs_pkg::ST_WAKE: begin
            // R4 first kick drops wake
            // R5 later kicks ignored
            if (kick_fall && !kicked_q) begin
               kicked_d   = 1'b1;
               out_d.wake = 1'b0;
            end
            if (tick) begin
               cnt_d = cnt_q + 1'b1;
               // R1 half period low
               if (cnt_q == HALF_T - 1'b1) begin
                  out_d.wake = 1'b0;
               end
               if (cnt_q == WAKE_T - 1'b1) begin
                  cnt_d = '0;
                  // R9 missed kick resets
                  if (!(kicked_q || kick_fall)) begin
                     state_d     = wwrs_pkg::ST_RESET;
                     out_d.rst_n = 1'b0;
                     out_d.wake  = 1'b0;
                  end else begin
                     // R1 next rising edge
                     kicked_d   = 1'b0;
                     out_d.wake = 1'b1;
                  end
               end
            end
         end
      endcase
      // R7 undervoltage asserts reset
      if (supply_bad) begin
         state_d     = wwrs_pkg::ST_RESET;
         cnt_d       = '0;
         out_d.rst_n = 1'b0;
         out_d.wake  = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= wwrs_pkg::ST_RESET;
         cnt_q     <= '0;
         kicked_q  <= 1'b0;
         powered_q <= 1'b0;
         out_q     <= '0;
      end else begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         kicked_q  <= kicked_d;
         powered_q <= powered_d;
         out_q     <= out_d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign wake_out    = out_q.wake;
   assign reset_n_out = out_q.rst_n;
endmodule : wwrs_top
`default_nettype wire

/* File: tb/wwrs_asserts.sv */
// port checker for the supervisor
`timescale 1ns/100ps
`default_nettype none
module wwrs_asserts #(
   parameter int unsigned TICK_DIV   = 2,
   parameter int unsigned UNIT_TICKS = 2
) (
   // clock and reset
   input  wire logic sys_clk_in,
   input  wire logic resetn_in,
   // watched pins
   input  wire logic out_good_in,
   input  wire logic undervolt_in,
   input  wire logic watchdog_kick_in,
   input  wire logic wake_out,
   input  wire logic reset_n_out
);
   // ****************************************************************
   // run counters
   // ****************************************************************
   localparam int HALF = 4 * UNIT_TICKS * TICK_DIV;
   localparam int RMIN = (UNIT_TICKS - 1) * TICK_DIV + 1;
   logic [15:0] hi_d, hi_q, lo_d, lo_q;
   always_comb begin
      hi_d = wake_out ? hi_q + 16'h1 : 16'h0;
      lo_d = reset_n_out ? 16'h0 : lo_q + 16'h1;
   end
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         hi_q <= 16'h0;
         lo_q <= 16'h0;
      end else begin
         hi_q <= hi_d;
         lo_q <= lo_d;
      end
   end
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   wake_in_rst_a: assert property (!reset_n_out |-> !wake_out)
      else $error("wake high during reset");
   uv_assert_a: assert property (undervolt_in |-> ##[1:6] !reset_n_out)
      else $error("undervolt gave no reset");
   uv_hold_a: assert property (undervolt_in [*6] |-> !reset_n_out)
      else $error("reset released in undervolt");
   kick_resp_a: assert property ($fell(watchdog_kick_in) && wake_out
      |-> ##[1:50] !wake_out) else $error("kick left wake high");
   kick_sync_a: assert property ($fell(watchdog_kick_in) && wake_out
      && hi_q < HALF - 4 |-> wake_out [*2]) else $error("kick not synced");
   wake_low_run_a: assert property ($fell(wake_out) |-> !wake_out [*8])
      else $error("wake low run too short");
   wake_half_a: assert property (hi_q <= HALF)
      else $error("wake high run too long");
   rst_width_a: assert property ($rose(reset_n_out) |-> lo_q >= RMIN)
      else $error("reset pulse too short");
   rst_to_wake_a: assert property ($rose(reset_n_out) |-> !wake_out [*8])
      else $error("wake rose too soon");
   rst_supply_a: assert property ($rose(reset_n_out)
      |-> $past(out_good_in, 4) && !$past(undervolt_in, 4))
      else $error("reset released on bad supply");
endmodule : wwrs_asserts
bind wwrs_top wwrs_asserts #(.TICK_DIV(TICK_DIV), .UNIT_TICKS(UNIT_TICKS))
   chk_u (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
   .out_good_in(out_good_in), .undervolt_in(undervolt_in),
   .watchdog_kick_in(watchdog_kick_in), .wake_out(wake_out),
   .reset_n_out(reset_n_out));
`default_nettype wire

/* File: tb/wwrs_cpu_model.sv */
// sleeping processor model that kicks the watchdog
`timescale 1ns/100ps
`default_nettype none
module wwrs_cpu_model (
   input  wire logic       clk_in,
   input  wire logic [1:0] mode_in,
   input  wire logic       wake_in,
   output logic            kick_out
);
   logic w_q = 1'b0;
   logic k_q = 1'b1;
   int   n   = 0;
   always @(posedge clk_in) begin
      w_q <= wake_in;
      n <= (wake_in && !w_q) ? 1 : ((n > 0) ? n + 1 : 0);
      // kick held low four clocks: the pin filter drops a one-clock pulse
      k_q <= !(mode_in != 2'h0 && ((n >= 3 && n <= 6) ||
               (mode_in == 2'h2 && n >= 10 && n <= 13)));
   end
   assign kick_out = (mode_in == 2'h3) ? wake_in : k_q;
endmodule : wwrs_cpu_model
`default_nettype wire

/* File: tb/wwrs_top_tb.sv */
// self-checking bench for the supervisor
`timescale 1ns/100ps
`default_nettype none
module wwrs_top_tb;
   // ****************************************************************
   // bench
   // ****************************************************************
   // small counts keep the run short
   localparam int TD   = 2;
   localparam int UT   = 2;
   localparam int HALF = 4 * UT * TD;
   localparam int RST  = UT * TD;
   logic       clk = 1'b0, rst_n = 1'b0, good = 1'b0, uv = 1'b0;
   logic       kick, wake, rsto;
   logic [1:0] mode = 2'h0;
   int         err_total = 0, check_count = 0, n, m;
   initial forever #20 clk = ~clk;
   wwrs_top #(.TICK_DIV(TD), .UNIT_TICKS(UT)) dut_u (.sys_clk_in(clk),
      .resetn_in(rst_n), .out_good_in(good), .undervolt_in(uv),
      .watchdog_kick_in(kick), .wake_out(wake), .reset_n_out(rsto));
   wwrs_cpu_model cpu_u (.clk_in(clk), .mode_in(mode), .wake_in(wake),
      .kick_out(kick));
   task automatic close_out();
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic v, input logic e, input string s);
      check_count++;
      if (v !== e) begin
         err_total++;
         $display("unexpected at %0t: %s", $time, s);
      end
   endtask : chk
   task automatic chk_n(input int v, input int lo, input int hi,
                        input string s);
      chk(v >= lo && v <= hi, 1'b1, s);
   endtask : chk_n
   // cycles until wake (sel 0) or reset (sel 1) shows v
   task automatic wt(input bit sel, input logic v, output int c);
      c = 0;
      do begin
         @(negedge clk);
         c++;
      end while ((sel ? rsto : wake) !== v && c < 400);
   endtask : wt
   task automatic s_power();
      repeat (40) @(negedge clk);
      chk(rsto, 1'b0, "reset before good");
      @(posedge clk) good <= 1'b1;
      wt(1, 1'b1, n);
      chk_n(n, RST + 1, RST + 7, "release delay");
      wt(0, 1'b1, n);
      chk_n(n, HALF - TD, HALF + TD, "reset to wake");
   endtask : s_power
   task automatic s_duty();
      @(posedge clk) mode <= 2'h3;
      wt(0, 1'b0, n);
      wt(0, 1'b1, n);
      wt(0, 1'b0, n);
      wt(0, 1'b1, m);
      chk_n(n, HALF - 1, HALF + 1, "high half");
      chk_n(m, HALF - 1, HALF + 1, "low half");
      chk(rsto, 1'b1, "tie back reset");
   endtask : s_duty
   task automatic s_kick(input logic [1:0] md);
      @(posedge clk) mode <= md;
      wt(0, 1'b0, n);
      wt(0, 1'b1, n);
      wt(0, 1'b0, n);
      wt(0, 1'b1, m);
      chk_n(n, 4, 14, "kick response");
      chk_n(n + m, 2 * HALF - 1, 2 * HALF + 1, "kicked period");
      chk(rsto, 1'b1, "kicked reset");
   endtask : s_kick
   task automatic s_miss();
      @(posedge clk) mode <= 2'h0;
      wt(1, 1'b0, n);
      chk_n(n, 1, 4 * HALF, "missed kick reset");
      chk(wake, 1'b0, "wake in reset");
      wt(1, 1'b1, n);
      chk_n(n, RST - 1, RST + 1, "pulse width");
      wt(0, 1'b1, n);
      chk_n(n, HALF - TD, HALF + TD, "wake restart");
   endtask : s_miss
   task automatic s_uv();
      @(posedge clk) mode <= 2'h1;
      uv <= 1'b1;
      repeat (20) @(negedge clk);
      chk(rsto, 1'b0, "undervolt reset");
      chk(wake, 1'b0, "undervolt wake");
      @(posedge clk) uv <= 1'b0;
      wt(1, 1'b1, n);
      chk_n(n, RST + 1, RST + 7, "recovery delay");
   endtask : s_uv
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      s_power();
      s_duty();
      s_kick(2'h1);
      s_kick(2'h2);
      s_miss();
      s_uv();
      close_out();
   end
   // watchdog: whole run needs about 350 cycles
   initial begin
      #(40 * 4000);
      err_total++;
      close_out();
   end
endmodule : wwrs_top_tb
`default_nettype wire
